//--- hdl/pin_mux_pkg.sv
// Constants for the multipurpose pin function multiplexer.
// Shared by the pin mux top, the pin host model and the bench; no other files are assumed.
package pin_mux_pkg;

    localparam int NUM_PINS         = 4;
    localparam int ADDR_W           = 8;
    localparam int DATA_W           = 16;
    localparam int CFG_W            = 9;
    localparam int DRIVE_ENABLE_BIT = 8;
    localparam int FUNC_W           = 8;
    localparam int RATE_W           = 3;
    localparam int NUM_CTRL         = 6;

    // Register indices; the byte address is four times the index.
    localparam logic [5:0] PIN0_CFG_INDEX   = 6'h10;
    localparam logic [5:0] PIN_STATUS_INDEX = 6'h14;

    // Decoded register slots: 0 to 3 are the pin configurations.
    localparam logic [2:0] SLOT_STATUS = 3'h4;
    localparam logic [2:0] SLOT_NONE   = 3'h7;

    // Per-pin reset values: direction bit and function code.
    localparam logic [NUM_PINS-1:0][CFG_W-1:0] CFG_RESET = {
        9'h087, 9'h086, 9'h102, 9'h180
    };

    // Status register field positions.
    localparam int STAT_PIN_LSB  = 0;
    localparam int STAT_CTRL_LSB = 4;

    // Output-direction function codes.
    localparam logic [FUNC_W-1:0] FN_OUT_LOW      = 8'h00;
    localparam logic [FUNC_W-1:0] FN_OUT_HIGH     = 8'h01;
    localparam logic [FUNC_W-1:0] FN_OUT_PLL_LOCK = 8'h02;
    localparam logic [FUNC_W-1:0] FN_OUT_LOS      = 8'h80;
    localparam logic [FUNC_W-1:0] FN_OUT_CARRIER  = 8'h81;
    localparam logic [FUNC_W-1:0] FN_OUT_SLEEP    = 8'h82;
    localparam logic [FUNC_W-1:0] FN_OUT_STD_DEF  = 8'h83;
    localparam logic [FUNC_W-1:0] FN_OUT_RATE0    = 8'h84;
    localparam logic [FUNC_W-1:0] FN_OUT_RATE1    = 8'h85;
    localparam logic [FUNC_W-1:0] FN_OUT_RATE2    = 8'h86;

    // Input-direction function codes.
    localparam logic [FUNC_W-1:0] FN_IN_COAX_DISABLE  = 8'h81;
    localparam logic [FUNC_W-1:0] FN_IN_TRACE_DISABLE = 8'h82;
    localparam logic [FUNC_W-1:0] FN_IN_EQ_BYPASS     = 8'h84;
    localparam logic [FUNC_W-1:0] FN_IN_RT_BYPASS     = 8'h85;
    localparam logic [FUNC_W-1:0] FN_IN_SLEEP         = 8'h86;
    localparam logic [FUNC_W-1:0] FN_IN_DRIVER_MODE   = 8'h87;

    // Bit positions of the internal controls.
    localparam int CTRL_COAX_DISABLE  = 0;
    localparam int CTRL_TRACE_DISABLE = 1;
    localparam int CTRL_EQ_BYPASS     = 2;
    localparam int CTRL_RT_BYPASS     = 3;
    localparam int CTRL_SLEEP         = 4;
    localparam int CTRL_DRIVER_MODE   = 5;

    // Pin level to control: two synchroniser stages and one output stage.
    localparam int SYNC_STAGES = 2;

endpackage : pin_mux_pkg

//--- hdl/pin_level_sync.sv
// Two-stage synchroniser for the multipurpose pin levels.
// Assumes asynchronous pin inputs and the core clock with an active-low reset.
`timescale 1ns/1ps
module pin_level_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pin_i,
    output logic      [WIDTH-1:0] pin_sync_o
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } sync_state_t;

    sync_state_t q;
    sync_state_t next_q;

    // The first stage feeds only the second, so metastability never reaches logic.
    always_comb begin
        next_q.stage1 = pin_i;
        next_q.stage2 = q.stage1;
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign pin_sync_o = q.stage2;

endmodule : pin_level_sync

//--- hdl/pin_function_mux.sv
// Direction and function multiplexing for the four multipurpose pins.
// Assumes status inputs from core-clock logic and asynchronous pin levels.
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module pin_function_mux #(
    parameter logic [pin_mux_pkg::RATE_W-1:0] STD_DEF_RATE_CODE = 3'h0
) (
    input  wire logic                               CLK_SYS_I,
    input  wire logic                               RST_N_I,
    input  wire logic [pin_mux_pkg::ADDR_W-1:0]     REG_ADDR_I,
    input  wire logic [pin_mux_pkg::DATA_W-1:0]     REG_WDATA_I,
    input  wire logic                               REG_WR_I,
    input  wire logic                               REG_RD_I,
    output logic      [pin_mux_pkg::DATA_W-1:0]     REG_RDATA_O,
    input  wire logic                               PLL_LOCKED_I,
    input  wire logic                               PRIMARY_CARRIER_PRESENT_I,
    input  wire logic                               SECONDARY_CARRIER_PRESENT_I,
    input  wire logic                               SLEEP_STATUS_I,
    input  wire logic [pin_mux_pkg::RATE_W-1:0]     DETECTED_RATE_I,
    input  wire logic                               TRACE_INPUT_ACTIVE_I,
    input  wire logic [pin_mux_pkg::NUM_PINS-1:0]   PIN_IN_I,
    output logic      [pin_mux_pkg::NUM_PINS-1:0]   PIN_OUT_O,
    output logic      [pin_mux_pkg::NUM_PINS-1:0]   PIN_OE_O,
    output logic                                    COAX_PORT_DISABLE_O,
    output logic                                    TRACE_OUTPUT_DISABLE_O,
    output logic                                    EQUALIZER_BYPASS_O,
    output logic                                    RETIMER_BYPASS_O,
    output logic                                    SLEEP_REQUEST_O,
    output logic                                    DRIVER_MODE_SELECT_O
);
    import pin_mux_pkg::*;

    typedef struct packed {
        logic [NUM_PINS-1:0][CFG_W-1:0] cfg;
        logic [DATA_W-1:0]              rdata;
        logic [NUM_PINS-1:0]            pin_out;
        logic [NUM_PINS-1:0]            pin_oe;
        logic [NUM_CTRL-1:0]            ctrl;
        logic                           live;
    } mux_state_t;

    localparam mux_state_t MUX_RESET = '{
        cfg:     CFG_RESET,
        rdata:   '0,
        pin_out: '0,
        pin_oe:  '0,
        ctrl:    '0,
        live:    1'b0
    };

    mux_state_t          q;
    mux_state_t          next_q;
    logic [NUM_PINS-1:0] pin_sync;
    logic [2:0]          wr_slot;
    logic [2:0]          rd_slot;
    logic                carrier_sel;
    logic                std_def_rate;

    // Maps a byte address to a register slot; misaligned or unmapped gives none.
    function automatic logic [2:0] decode_slot(input logic [ADDR_W-1:0] addr);
        logic [5:0] idx;
        idx = addr[ADDR_W-1:2];
        if (addr[1:0] != 2'h0) begin
            return SLOT_NONE;
        end else if (idx == PIN_STATUS_INDEX) begin
            return SLOT_STATUS;
        end else if (idx >= PIN0_CFG_INDEX && idx < PIN_STATUS_INDEX) begin
            return {1'b0, 2'(idx - PIN0_CFG_INDEX)};
        end
        return SLOT_NONE;
    endfunction : decode_slot

    // Level driven by a pin in output direction; reserved codes drive low.
    function automatic logic out_level(input logic [FUNC_W-1:0] code,
                                       input logic              carrier,
                                       input logic              std_def);
        case (code)
            FN_OUT_LOW:      return 1'b0;
            FN_OUT_HIGH:     return 1'b1;
            FN_OUT_PLL_LOCK: return PLL_LOCKED_I;
            FN_OUT_LOS:      return !carrier;
            FN_OUT_CARRIER:  return carrier;
            FN_OUT_SLEEP:    return SLEEP_STATUS_I;
            FN_OUT_STD_DEF:  return std_def;
            FN_OUT_RATE0:    return DETECTED_RATE_I[0];
            FN_OUT_RATE1:    return DETECTED_RATE_I[1];
            FN_OUT_RATE2:    return DETECTED_RATE_I[2];
            default:         return 1'b0;
        endcase
    endfunction : out_level

    // Control claimed by an input-direction code; reserved codes claim none.
    function automatic logic [NUM_CTRL-1:0] in_claim(input logic [FUNC_W-1:0] code);
        logic [NUM_CTRL-1:0] mask;
        mask = '0;
        case (code)
            FN_IN_COAX_DISABLE:  mask[CTRL_COAX_DISABLE]  = 1'b1;
            FN_IN_TRACE_DISABLE: mask[CTRL_TRACE_DISABLE] = 1'b1;
            FN_IN_EQ_BYPASS:     mask[CTRL_EQ_BYPASS]     = 1'b1;
            FN_IN_RT_BYPASS:     mask[CTRL_RT_BYPASS]     = 1'b1;
            FN_IN_SLEEP:         mask[CTRL_SLEEP]         = 1'b1;
            FN_IN_DRIVER_MODE:   mask[CTRL_DRIVER_MODE]   = 1'b1;
            default:             mask = '0;
        endcase
        return mask;
    endfunction : in_claim

    pin_level_sync #(
        .WIDTH      (NUM_PINS)
    ) u_pin_sync (
        .clk_sys_i  (CLK_SYS_I),
        .rst_n_i    (RST_N_I),
        .pin_i      (PIN_IN_I),
        .pin_sync_o (pin_sync)
    );

    always_comb begin
        next_q      = q;
        // Checkers wait for this flag, as the edge that releases reset still loads reset values.
        next_q.live = 1'b1;
        wr_slot     = decode_slot(REG_ADDR_I);
        rd_slot     = decode_slot(REG_ADDR_I);
        carrier_sel = TRACE_INPUT_ACTIVE_I ? PRIMARY_CARRIER_PRESENT_I
                                           : SECONDARY_CARRIER_PRESENT_I;
        std_def_rate = (DETECTED_RATE_I == STD_DEF_RATE_CODE);

        // Bits 15:9 are not stored, so they always read back as zero.
        if (REG_WR_I && wr_slot < SLOT_STATUS) begin
            next_q.cfg[wr_slot[1:0]] = REG_WDATA_I[CFG_W-1:0];
        end

        // Read data stands for exactly one cycle; unmapped reads return zero.
        next_q.rdata = '0;
        if (REG_RD_I && rd_slot < SLOT_STATUS) begin
            next_q.rdata = {{(DATA_W-CFG_W){1'b0}}, q.cfg[rd_slot[1:0]]};
        end else if (REG_RD_I && rd_slot == SLOT_STATUS) begin
            next_q.rdata[STAT_PIN_LSB +: NUM_PINS]  = pin_sync;
            next_q.rdata[STAT_CTRL_LSB +: NUM_CTRL] = q.ctrl;
        end

        next_q.ctrl = '0;
        for (int i = 0; i < NUM_PINS; i++) begin
            next_q.pin_oe[i] = q.cfg[i][DRIVE_ENABLE_BIT];
            if (q.cfg[i][DRIVE_ENABLE_BIT]) begin
                next_q.pin_out[i] = out_level(q.cfg[i][FUNC_W-1:0], carrier_sel, std_def_rate);
            end else begin
                next_q.pin_out[i] = 1'b0;
                // Several pins claiming one control are ORed together.
                next_q.ctrl = next_q.ctrl
                            | (in_claim(q.cfg[i][FUNC_W-1:0]) & {NUM_CTRL{pin_sync[i]}});
            end
        end

        // Equalizer bypass has no meaning while the trace input is the source.
        if (TRACE_INPUT_ACTIVE_I) begin
            next_q.ctrl[CTRL_EQ_BYPASS] = 1'b0;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            q <= MUX_RESET;
        end else begin
            q <= next_q;
        end
    end

    assign REG_RDATA_O            = q.rdata;
    assign PIN_OUT_O              = q.pin_out;
    assign PIN_OE_O               = q.pin_oe;
    assign COAX_PORT_DISABLE_O    = q.ctrl[CTRL_COAX_DISABLE];
    assign TRACE_OUTPUT_DISABLE_O = q.ctrl[CTRL_TRACE_DISABLE];
    assign EQUALIZER_BYPASS_O     = q.ctrl[CTRL_EQ_BYPASS];
    assign RETIMER_BYPASS_O       = q.ctrl[CTRL_RT_BYPASS];
    assign SLEEP_REQUEST_O        = q.ctrl[CTRL_SLEEP];
    assign DRIVER_MODE_SELECT_O   = q.ctrl[CTRL_DRIVER_MODE];

    default clocking cb @(posedge CLK_SYS_I);
    endclocking

    default disable iff (!RST_N_I || !q.live);

    // A pin-0 input code held over the whole path makes a high level reach its control.
    property pin0_ctrl(logic [CFG_W-1:0] code, logic gate, logic ctl);
        (PIN_IN_I[0] && q.cfg[0] == code) ##1 (q.cfg[0] == code)
        ##1 (q.cfg[0] == code && gate) |=> ctl;
    endproperty

    for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin_check
        AST_INPUT_TRISTATE: assert property (
            !q.cfg[p][DRIVE_ENABLE_BIT] |=> !PIN_OE_O[p] && !PIN_OUT_O[p]
        ) else $error("Input-direction pin is driven.");
        AST_OUTPUT_DRIVES: assert property (
            q.cfg[p][DRIVE_ENABLE_BIT] |=> PIN_OE_O[p]
        ) else $error("Output-direction pin is not driven.");
        AST_CONST_LEVEL: assert property (
            q.cfg[p] == 9'h101 |=> PIN_OUT_O[p]
        ) else $error("Constant high code does not drive high.");
        AST_CONST_LOW: assert property (
            q.cfg[p] == 9'h100 |=> !PIN_OUT_O[p]
        ) else $error("Constant low code does not drive low.");
        AST_PLL_LOCK: assert property (
            q.cfg[p] == 9'h102 |=> PIN_OUT_O[p] == $past(PLL_LOCKED_I)
        ) else $error("Pin does not follow PLL lock.");
        AST_LOS: assert property (
            q.cfg[p] == 9'h180 |=> PIN_OUT_O[p] == $past(TRACE_INPUT_ACTIVE_I ?
                !PRIMARY_CARRIER_PRESENT_I : !SECONDARY_CARRIER_PRESENT_I)
        ) else $error("Pin does not show loss of signal.");
        AST_CARRIER: assert property (
            q.cfg[p] == 9'h181 |=> PIN_OUT_O[p] == $past(TRACE_INPUT_ACTIVE_I ?
                PRIMARY_CARRIER_PRESENT_I : SECONDARY_CARRIER_PRESENT_I)
        ) else $error("Pin does not show carrier detect.");
        AST_SLEEP_OUT: assert property (
            q.cfg[p] == 9'h182 |=> PIN_OUT_O[p] == $past(SLEEP_STATUS_I)
        ) else $error("Pin does not show sleep status.");
        AST_STD_DEF_FLAG: assert property (
            q.cfg[p] == 9'h183 |=> PIN_OUT_O[p] == ($past(DETECTED_RATE_I) == STD_DEF_RATE_CODE)
        ) else $error("Pin does not flag the standard-definition rate.");
        AST_RATE_BIT: assert property (
            q.cfg[p] == 9'h186 |=> PIN_OUT_O[p] == $past(DETECTED_RATE_I[2])
        ) else $error("Pin does not show detected-rate bit two.");
        AST_RATE_BIT_ZERO: assert property (
            q.cfg[p] == 9'h184 |=> PIN_OUT_O[p] == $past(DETECTED_RATE_I[0])
        ) else $error("Pin does not show detected-rate bit zero.");
        AST_RATE_BIT_ONE: assert property (
            q.cfg[p] == 9'h185 |=> PIN_OUT_O[p] == $past(DETECTED_RATE_I[1])
        ) else $error("Pin does not show detected-rate bit one.");
        AST_RESERVED_OUT: assert property (
            q.cfg[p][DRIVE_ENABLE_BIT] && q.cfg[p][7:0] inside {[8'h03:8'h7f], [8'h87:8'hff]}
            |=> !PIN_OUT_O[p]
        ) else $error("Reserved output code drives high.");
    end

    AST_CFG_HOLDS: assert property (
        !REG_WR_I |=> $stable(q.cfg)
    ) else $error("Pin configuration changed without a write.");

    AST_RDATA_IDLE: assert property (
        !REG_RD_I |=> REG_RDATA_O == '0
    ) else $error("Read data stands without a read.");

    AST_READBACK: assert property (
        REG_RD_I && REG_ADDR_I == 8'h44 |=> REG_RDATA_O == {7'h00, $past(q.cfg[1])}
    ) else $error("Pin one configuration reads back wrong.");

    AST_SYNC_DELAY: assert property (
        ##2 pin_sync == $past(PIN_IN_I, 2)
    ) else $error("Pin level does not pass two synchroniser stages.");

    AST_COAX_DISABLE: assert property (
        pin0_ctrl(9'h081, 1'b1, COAX_PORT_DISABLE_O)
    ) else $error("High pin does not disable the coax port.");

    AST_TRACE_DISABLE: assert property (
        pin0_ctrl(9'h082, 1'b1, TRACE_OUTPUT_DISABLE_O)
    ) else $error("High pin does not disable the trace output.");

    AST_EQ_BYPASS: assert property (
        pin0_ctrl(9'h084, !TRACE_INPUT_ACTIVE_I, EQUALIZER_BYPASS_O)
    ) else $error("High pin does not bypass the equalizer.");

    AST_EQ_TRACE_BLOCK: assert property (
        TRACE_INPUT_ACTIVE_I |=> !EQUALIZER_BYPASS_O
    ) else $error("Equalizer bypass applied with trace input active.");

    AST_RT_BYPASS: assert property (
        pin0_ctrl(9'h085, 1'b1, RETIMER_BYPASS_O)
    ) else $error("High pin does not bypass the retimer.");

    AST_SLEEP_PIN: assert property (
        pin0_ctrl(9'h086, 1'b1, SLEEP_REQUEST_O)
    ) else $error("High pin does not request sleep.");

    AST_DRIVER_MODE: assert property (
        pin0_ctrl(9'h087, 1'b1, DRIVER_MODE_SELECT_O)
    ) else $error("High pin does not select driver mode.");

    AST_NO_INPUT_NO_CTRL: assert property (
        (&PIN_OE_O) && (q.cfg[0][8] && q.cfg[1][8] && q.cfg[2][8] && q.cfg[3][8])
        |=> q.ctrl == '0
    ) else $error("Control asserted with no pin in input direction.");

    COV_LOCK_OUT: cover property (q.cfg[1] == 9'h102 ##1 PIN_OUT_O[1]);
    COV_SLEEP_IN: cover property (q.cfg[2] == 9'h086 ##3 SLEEP_REQUEST_O);
    COV_CFG_WRITE: cover property (REG_WR_I ##1 !REG_WR_I ##1 PIN_OE_O[0] == 1'b0);
    COV_STATUS_READ: cover property (REG_RD_I && REG_ADDR_I == 8'h50 ##1 REG_RDATA_O != '0);

endmodule : pin_function_mux

//--- verif/pin_host_model.sv
// Board host logic on the far side of the four multipurpose pins.
// Assumes the device drives a pin only while its output enable is high.
`timescale 1ns/1ps
module pin_host_model
    import pin_mux_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic [NUM_PINS-1:0] pin_out_i,
    input  wire logic [NUM_PINS-1:0] pin_oe_i,
    input  wire logic [NUM_PINS-1:0] host_en_i,
    input  wire logic [NUM_PINS-1:0] host_level_i,
    output logic      [NUM_PINS-1:0] pin_level_o
);
    logic [NUM_PINS-1:0] float_pattern = 4'h5;

    // A pin with nobody driving it has no pull, so it wanders instead of keeping a level.
    always @(posedge clk_i) begin
        float_pattern <= ~float_pattern;
    end

    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            pin_level_o[i] = pin_oe_i[i] ? pin_out_i[i] :
                             (host_en_i[i] ? host_level_i[i] : float_pattern[i]);
        end
    end
endmodule : pin_host_model

//--- verif/pin_function_mux_tb.sv
// Self-checking bench for the pin function multiplexer.
// Assumes the host model on the pins and a register port with one-cycle read latency.
`timescale 1ns/1ps
module pin_function_mux_tb;
    import pin_mux_pkg::*;
    localparam logic [RATE_W-1:0] STD_DEF_CODE = 3'h5;
    logic        clk, rst_n, reg_wr, reg_rd, pll, pcd, scd, slp, trace_act;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata, rd;
    logic [2:0]  rate;
    logic [3:0]  pin_in, pin_out, pin_oe, host_en, host_level;
    wire  [5:0]  ctrl;
    int          n_errors = 0;
    int          n_tests = 0;

    pin_function_mux #(.STD_DEF_RATE_CODE(STD_DEF_CODE)) u_dut (
        .CLK_SYS_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(reg_addr), .REG_WDATA_I(reg_wdata),
        .REG_WR_I(reg_wr), .REG_RD_I(reg_rd), .REG_RDATA_O(reg_rdata), .PLL_LOCKED_I(pll),
        .PRIMARY_CARRIER_PRESENT_I(pcd), .SECONDARY_CARRIER_PRESENT_I(scd),
        .SLEEP_STATUS_I(slp), .DETECTED_RATE_I(rate), .TRACE_INPUT_ACTIVE_I(trace_act),
        .PIN_IN_I(pin_in), .PIN_OUT_O(pin_out), .PIN_OE_O(pin_oe),
        .COAX_PORT_DISABLE_O(ctrl[0]), .TRACE_OUTPUT_DISABLE_O(ctrl[1]),
        .EQUALIZER_BYPASS_O(ctrl[2]), .RETIMER_BYPASS_O(ctrl[3]),
        .SLEEP_REQUEST_O(ctrl[4]), .DRIVER_MODE_SELECT_O(ctrl[5]));

    pin_host_model u_host (.clk_i(clk), .pin_out_i(pin_out), .pin_oe_i(pin_oe),
        .host_en_i(host_en), .host_level_i(host_level), .pin_level_o(pin_in));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    function automatic logic exp_out(input logic [7:0] code);
        case (code)
            8'h01:   return 1'b1;
            8'h02:   return pll;
            8'h80:   return ~(trace_act ? pcd : scd);
            8'h81:   return trace_act ? pcd : scd;
            8'h82:   return slp;
            8'h83:   return rate == STD_DEF_CODE;
            8'h84:   return rate[0];
            8'h85:   return rate[1];
            8'h86:   return rate[2];
            default: return 1'b0;
        endcase
    endfunction : exp_out

    task automatic test_reset_and_map;
        logic [15:0] exp_cfg [4] = '{16'h0180, 16'h0102, 16'h0086, 16'h0087};
        check(16'(pin_oe), 16'h0003);
        for (int i = 0; i < 4; i++) begin
            reg_read(8'h40 + 8'(4 * i), rd);
            check(rd, exp_cfg[i]);
        end
        @(posedge clk);
        #1 check(reg_rdata, 16'h0000);
        reg_write(8'h60, 16'h01ff);
        reg_read(8'h60, rd);
        check(rd, 16'h0000);
        reg_read(8'h41, rd);
        check(rd, 16'h0000);
        reg_write(8'h40, 16'hfe81);
        reg_read(8'h40, rd);
        check(rd, 16'h0081);
        $display("test_reset_and_map done");
    endtask : test_reset_and_map

    task automatic test_output_codes;
        logic [7:0] codes [12] = '{8'h00, 8'h01, 8'h02, 8'h80, 8'h81, 8'h82, 8'h83,
                                   8'h84, 8'h85, 8'h86, 8'h03, 8'h87};
        for (int v = 0; v < 2; v++) begin
            @(posedge clk);
            pll       <= (v == 0);
            pcd       <= (v == 0);
            scd       <= (v != 0);
            slp       <= (v != 0);
            trace_act <= (v == 0);
            rate      <= (v == 0) ? 3'h5 : 3'h2;
            for (int i = 0; i < 12; i++) begin
                reg_write(8'h40, {8'h01, codes[i]});
                @(posedge clk);
                #1 check(16'(pin_out[0]),
                    16'(exp_out(codes[i])));
                check(16'(pin_oe[0]), 16'h0001);
                check(16'(pin_out[1]), 16'(pll));
            end
        end
        $display("test_output_codes done");
    endtask : test_output_codes

    task automatic test_input_codes;
        // The last two codes are reserved; the host writes them only to prove they do nothing.
        logic [7:0] codes [9] = '{8'h81, 8'h82, 8'h84, 8'h85, 8'h86, 8'h87,
                                  8'h84, 8'h83, 8'h80};
        logic [5:0] exps [9]  = '{6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00, 6'h00, 6'h00};
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            trace_act     <= (i == 6);
            host_level[0] <= 1'b1;
            reg_write(8'h40, {8'h00, codes[i]});
            repeat (4) @(posedge clk);
            #1 check(16'(ctrl), 16'(exps[i]));
            check(16'(pin_oe[0]), 16'h0000);
            reg_read(8'h50, rd);
            check(rd, {6'h00, exps[i], 2'b00, pll, 1'b1});
            @(posedge clk);
            host_level[0] <= 1'b0;
            repeat (4) @(posedge clk);
            #1 check(16'(ctrl), 16'h0000);
        end
        $display("test_input_codes done");
    endtask : test_input_codes

    task automatic test_sync_latency;
        reg_write(8'h40, 16'h0100);
        @(posedge clk);
        host_level[2] <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check(16'(ctrl[CTRL_SLEEP]), 16'h0000);
        @(posedge clk);
        #1 check(16'(ctrl[CTRL_SLEEP]), 16'h0001);
        @(posedge clk);
        host_level[3] <= 1'b1;
        repeat (4) @(posedge clk);
        #1 check(16'(ctrl), 16'h0030);
        reg_write(8'h48, 16'h0182);
        reg_write(8'h4c, 16'h0186);
        repeat (3) @(posedge clk);
        #1 check(16'(pin_oe), 16'h000f);
        check(16'(ctrl), 16'h0000);
        check(16'(pin_out[2]), 16'(slp));
        $display("test_sync_latency done");
    endtask : test_sync_latency

    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #(8 * 20000);
        n_errors++;
        $display("[FAIL] %0t: watchdog expired", $time);
        wrap_up();
    end

    initial begin
        rst_n = 1'b0;
        {reg_wr, reg_rd, pll, pcd, scd, slp, trace_act} = '0;
        reg_addr   = 8'h00;
        reg_wdata  = 16'h0000;
        rate       = 3'h0;
        host_en    = 4'hf;
        host_level = 4'h0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        test_reset_and_map();
        test_output_codes();
        test_input_codes();
        test_sync_latency();
        wrap_up();
    end
endmodule : pin_function_mux_tb
